// *** design/tdc_consts.vh ***
// Register map, field layout, reset values and timing counts of the tap configuration bank
`ifndef TDC_CONSTS_VH
`define TDC_CONSTS_VH

// Register word indices; byte address is four times the index
`define TDC_IDX_TAP_TIMING     8'h63
`define TDC_IDX_TAP_THRESHOLD  8'h64
`define TDC_IDX_ORIENT_CFG0    8'h65
`define TDC_IDX_INT_DATA       8'h58
`define TDC_IDX_DET_CTRL       8'h70
`define TDC_IDX_STATUS         8'h71
`define TDC_IDX_IRQ_STAT       8'h72
`define TDC_IDX_IRQ_MASK       8'h73
`define TDC_ADDR_W             10

// Field positions
`define TDC_QUIET_BIT          7
`define TDC_SHOCK_BIT          6
`define TDC_DUR_HI             2
`define TDC_DUR_LO             0
`define TDC_TH_HI              4
`define TDC_TH_LO              0
`define TDC_HYST_HI            7
`define TDC_HYST_LO            4
`define TDC_DATA_TAP_BIT       3
`define TDC_CTRL_RANGE_HI      1
`define TDC_CTRL_RANGE_LO      0
`define TDC_CTRL_LP_REQ_BIT    2

// Writable masks (reserved bits read as zero)
`define TDC_TIMING_WMASK       8'hC7
`define TDC_THRESH_WMASK       8'h1F
`define TDC_ORIENT_WMASK       8'hFF
`define TDC_DATA_WMASK         8'h08
`define TDC_CTRL_WMASK         8'h07

// Reset values
`define TDC_TIMING_RST         8'h04
`define TDC_THRESH_RST         8'h0A
`define TDC_ORIENT_RST         8'h18
`define TDC_DATA_RST           8'h00
`define TDC_CTRL_RST           8'h00

// Times in ms; clock rate in kHz
`define TDC_QUIET_MS_0         30
`define TDC_QUIET_MS_1         20
`define TDC_SHOCK_MS_0         50
`define TDC_SHOCK_MS_1         75
`define TDC_WIN_MS_0           50
`define TDC_WIN_MS_1           100
`define TDC_WIN_MS_2           150
`define TDC_WIN_MS_3           200
`define TDC_WIN_MS_4           250
`define TDC_WIN_MS_5           375
`define TDC_WIN_MS_6           500
`define TDC_WIN_MS_7           700
`define TDC_CLK_KHZ            20000

// Thresholds in 1/100 mg; tap threshold code zero counts as one half, hysteresis code zero is zero
`define TDC_TH_STEP_2G_CMG     6250
`define TDC_HYST_STEP_CMG      6250

// Irq status bits
`define TDC_IRQ_CFG_BIT        0
`define TDC_IRQ_LP_BIT         1

`endif

// *** design/tdc_dur_rom.v ***
// Registered lookup of double-tap window length in ms
`timescale 1ns/1ns
module tdc_dur_rom
(
    input  wire        clk,
    input  wire        nrst,
    input  wire [2:0]  code,
    output reg  [9:0]  win_ms_q
);
`include "tdc_consts.vh"

    reg [9:0] win_ms_d;

    always @*
    begin
        case (code)
            3'h0:    win_ms_d = 10'd`TDC_WIN_MS_0;
            3'h1:    win_ms_d = 10'd`TDC_WIN_MS_1;
            3'h2:    win_ms_d = 10'd`TDC_WIN_MS_2;
            3'h3:    win_ms_d = 10'd`TDC_WIN_MS_3;
            3'h4:    win_ms_d = 10'd`TDC_WIN_MS_4;
            3'h5:    win_ms_d = 10'd`TDC_WIN_MS_5;
            3'h6:    win_ms_d = 10'd`TDC_WIN_MS_6;
            default: win_ms_d = 10'd`TDC_WIN_MS_7;
        endcase
    end

    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            win_ms_q <= 10'h0FA;
        else
            win_ms_q <= win_ms_d;
    end
endmodule // tdc_dur_rom

// *** design/tdc_regs.v ***
// Tap detector configuration bank behind an Avalon-MM slave
`timescale 1ns/1ns
module tdc_regs
(
    input  wire        clk,
    input  wire        nrst,
    input  wire [9:0]  avs_address,
    input  wire        avs_read,
    input  wire        avs_write,
    input  wire [31:0] avs_writedata,
    input  wire [3:0]  avs_byteenable,
    output reg  [31:0] avs_readdata,
    output wire        avs_waitrequest,
    output wire [1:0]  avs_response,
    output reg  [19:0] quiet_cycles,
    output reg  [20:0] shock_cycles,
    output reg  [23:0] window_cycles,
    output reg  [20:0] knock_threshold_cmg,
    output reg  [9:0]  hyst_cmg,
    output reg         low_power_en,
    output wire        irq
);
`include "tdc_consts.vh"

    // Full-width products, then cut to the output widths on purpose
    localparam [31:0] QUIET_0_W = `TDC_QUIET_MS_0 * `TDC_CLK_KHZ;
    localparam [31:0] QUIET_1_W = `TDC_QUIET_MS_1 * `TDC_CLK_KHZ;
    localparam [31:0] SHOCK_0_W = `TDC_SHOCK_MS_0 * `TDC_CLK_KHZ;
    localparam [31:0] SHOCK_1_W = `TDC_SHOCK_MS_1 * `TDC_CLK_KHZ;
    localparam [31:0] KHZ_W     = `TDC_CLK_KHZ;
    localparam [19:0] QUIET_0   = QUIET_0_W[19:0];
    localparam [19:0] QUIET_1   = QUIET_1_W[19:0];
    localparam [20:0] SHOCK_0   = SHOCK_0_W[20:0];
    localparam [20:0] SHOCK_1   = SHOCK_1_W[20:0];
    localparam [14:0] KHZ       = KHZ_W[14:0];

    // One-hot bus states
    localparam [1:0] ST_IDLE = 2'b01;
    localparam [1:0] ST_ACK  = 2'b10;

    ////////////////////////////////////////////////////////////////////////
    reg  [1:0]  state_q;
    reg  [7:0]  timing_q;
    reg  [7:0]  thresh_q;
    reg  [7:0]  orient_q;
    reg  [7:0]  data_q;
    reg  [7:0]  ctrl_q;
    reg  [1:0]  irq_stat_q;
    reg  [1:0]  irq_mask_q;
    reg         lp_blocked_q;
    reg         decode_ok;
    reg  [7:0]  rd_byte;
    wire [7:0]  idx;
    wire        req;
    wire        we;
    wire [7:0]  wb;
    wire        cfg_ev;
    wire        lp_blk_now;
    wire [9:0]  win_ms_q;
    wire [16:0] hyst_prod;
    wire [16:0] hyst_div;

    assign idx = avs_address[9:2];
    assign req = avs_read | avs_write;
    assign wb  = avs_writedata[7:0];
    // Write takes effect in the acknowledge cycle only
    assign we  = (state_q == ST_ACK) & avs_write & avs_byteenable[0];
    assign avs_waitrequest = req & (state_q != ST_ACK);
    assign avs_response    = decode_ok ? 2'h0 : 2'h3;

    always @*
    begin
        decode_ok = 1'b1;
        rd_byte   = 8'h00;
        case (idx)
            `TDC_IDX_TAP_TIMING:    rd_byte = timing_q;
            `TDC_IDX_TAP_THRESHOLD: rd_byte = thresh_q;
            `TDC_IDX_ORIENT_CFG0:   rd_byte = orient_q;
            `TDC_IDX_INT_DATA:      rd_byte = data_q;
            `TDC_IDX_DET_CTRL:      rd_byte = ctrl_q;
            `TDC_IDX_STATUS:        rd_byte = {7'h00, lp_blocked_q};
            `TDC_IDX_IRQ_STAT:      rd_byte = {6'h00, irq_stat_q};
            `TDC_IDX_IRQ_MASK:      rd_byte = {6'h00, irq_mask_q};
            default:                decode_ok = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Bus handshake: one wait cycle, then acknowledge
    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            state_q      <= ST_IDLE;
            avs_readdata <= 32'h00000000;
        end
        else
        begin
            case (state_q)
                ST_IDLE:
                begin
                    if (req)
                    begin
                        state_q      <= ST_ACK;
                        avs_readdata <= {24'h000000, rd_byte};
                    end
                end
                ST_ACK:  state_q <= ST_IDLE;
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // Reserved bits masked off on write and read as zero
    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            timing_q   <= `TDC_TIMING_RST;
            thresh_q   <= `TDC_THRESH_RST;
            orient_q   <= `TDC_ORIENT_RST;
            data_q     <= `TDC_DATA_RST;
            ctrl_q     <= `TDC_CTRL_RST;
            irq_mask_q <= 2'h0;
        end
        else if (we)
        begin
            case (idx)
                `TDC_IDX_TAP_TIMING:    timing_q <= wb & `TDC_TIMING_WMASK;
                `TDC_IDX_TAP_THRESHOLD: thresh_q <= wb & `TDC_THRESH_WMASK;
                `TDC_IDX_ORIENT_CFG0:   orient_q <= wb & `TDC_ORIENT_WMASK;
                `TDC_IDX_INT_DATA:      data_q   <= wb & `TDC_DATA_WMASK;
                `TDC_IDX_DET_CTRL:      ctrl_q   <= wb & `TDC_CTRL_WMASK;
                `TDC_IDX_IRQ_MASK:      irq_mask_q <= wb[1:0];
                default:                ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Low-power gate and sticky events
    assign lp_blk_now = data_q[`TDC_DATA_TAP_BIT];
    assign cfg_ev = we & ((idx == `TDC_IDX_TAP_TIMING) | (idx == `TDC_IDX_TAP_THRESHOLD));

    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            low_power_en <= 1'b0;
            lp_blocked_q <= 1'b0;
            irq_stat_q   <= 2'h0;
        end
        else
        begin
            lp_blocked_q <= lp_blk_now & ctrl_q[`TDC_CTRL_LP_REQ_BIT];
            low_power_en <= ctrl_q[`TDC_CTRL_LP_REQ_BIT] & ~lp_blk_now;
            // Set wins over write-one-to-clear
            irq_stat_q[`TDC_IRQ_CFG_BIT] <= cfg_ev | (irq_stat_q[`TDC_IRQ_CFG_BIT] &
                ~(we & (idx == `TDC_IDX_IRQ_STAT) & wb[`TDC_IRQ_CFG_BIT]));
            irq_stat_q[`TDC_IRQ_LP_BIT] <= (lp_blk_now & ctrl_q[`TDC_CTRL_LP_REQ_BIT]) |
                (irq_stat_q[`TDC_IRQ_LP_BIT] &
                ~(we & (idx == `TDC_IDX_IRQ_STAT) & wb[`TDC_IRQ_LP_BIT]));
        end
    end

    assign irq = |(irq_stat_q & irq_mask_q);

    ////////////////////////////////////////////////////////////////////////
    tdc_dur_rom u_rom
    (
        .clk      (clk),
        .nrst     (nrst),
        .code     (timing_q[`TDC_DUR_HI:`TDC_DUR_LO]),
        .win_ms_q (win_ms_q)
    );

    // Hysteresis product needs 17 bits before scaling down
    assign hyst_prod = orient_q[`TDC_HYST_HI:`TDC_HYST_LO] * 17'd`TDC_HYST_STEP_CMG;
    assign hyst_div  = hyst_prod / 17'd100;

    // Detector parameters follow live register contents
    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            quiet_cycles        <= QUIET_0;
            shock_cycles        <= SHOCK_0;
            window_cycles       <= 24'h4C4B40;
            knock_threshold_cmg <= 21'h00F424;
            hyst_cmg            <= 10'h03E;
        end
        else
        begin
            quiet_cycles <= timing_q[`TDC_QUIET_BIT] ? QUIET_1 : QUIET_0;
            shock_cycles <= timing_q[`TDC_SHOCK_BIT] ? SHOCK_1 : SHOCK_0;
            window_cycles <= win_ms_q * KHZ;
            // Step doubles per range; code 0 gives half step
            if (thresh_q[`TDC_TH_HI:`TDC_TH_LO] == 5'h00)
                knock_threshold_cmg <= (21'd`TDC_TH_STEP_2G_CMG >> 1)
                                       << ctrl_q[`TDC_CTRL_RANGE_HI:`TDC_CTRL_RANGE_LO];
            else
                knock_threshold_cmg <= (thresh_q[`TDC_TH_HI:`TDC_TH_LO] * 21'd`TDC_TH_STEP_2G_CMG)
                                       << ctrl_q[`TDC_CTRL_RANGE_HI:`TDC_CTRL_RANGE_LO];
            // Range-independent step
            hyst_cmg <= hyst_div[9:0];
        end
    end
endmodule // tdc_regs

// *** bench/tdc_regs_sva.sv ***
// Port assertions for the tap configuration bank
`timescale 1ns/1ns
module tdc_regs_sva
(
    input wire logic        clk,
    input wire logic        nrst,
    input wire logic [9:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0]  avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic [1:0]  avs_response,
    input wire logic [19:0] quiet_cycles,
    input wire logic [20:0] shock_cycles,
    input wire logic [23:0] window_cycles
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    wire rq = avs_read | avs_write;
    function automatic logic [23:0] win_f(input logic [2:0] c);
        case (c)
            3'h5: win_f = 24'd7500000;
            3'h6: win_f = 24'd10000000;
            3'h7: win_f = 24'd14000000;
            default: win_f = 24'((c + 1) * 1000000);
        endcase
    endfunction
    function automatic logic mapped_f(input logic [9:0] a);
        mapped_f = a[9:2] inside {8'h58, 8'h63, 8'h64, 8'h65, 8'h70, 8'h71, 8'h72, 8'h73};
    endfunction
    sequence ack_s;
        rq && !avs_waitrequest;
    endsequence
    sequence tim_wr_s;
        ack_s ##0 (avs_write && avs_byteenable[0] && avs_address == 10'h18C);
    endsequence
    wait_first_a: assert property (!rq ##1 rq |-> avs_waitrequest)
        else $error("first request cycle not stalled");
    ack_next_a: assert property (rq && avs_waitrequest |=> !avs_waitrequest)
        else $error("request stalled beyond one cycle");
    unmap_resp_a: assert property (ack_s ##0 !mapped_f(avs_address)
        |-> avs_response == 2'b11 && (avs_write || avs_readdata == 32'h0))
        else $error("unmapped access not refused");
    map_resp_a: assert property (ack_s ##0 mapped_f(avs_address) |-> avs_response == 2'b00)
        else $error("mapped access refused");
    read_hold_a: assert property (ack_s ##0 avs_read ##1 !rq |-> $stable(avs_readdata))
        else $error("read data moved while idle");
    quiet_sel_a: assert property (tim_wr_s |-> ##2 quiet_cycles ==
        ($past(avs_writedata[7], 2) ? 20'd400000 : 20'd600000))
        else $error("quiet interval wrong");
    shock_sel_a: assert property (tim_wr_s |-> ##2 shock_cycles ==
        ($past(avs_writedata[6], 2) ? 21'd1500000 : 21'd1000000))
        else $error("shock interval wrong");
    window_sel_a: assert property (tim_wr_s |-> ##3
        window_cycles == win_f($past(avs_writedata[2:0], 3)))
        else $error("double tap window wrong");
endmodule // tdc_regs_sva
bind tdc_regs tdc_regs_sva u_sva (.clk, .nrst, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .avs_response,
    .quiet_cycles, .shock_cycles, .window_cycles);

// *** bench/tdc_regs_tb_top.sv ***
// Self-checking bench for the tap configuration bank
`timescale 1ns/1ns
module tdc_regs_tb_top;
    logic        clk = 1'b0;
    logic        nrst = 1'b0;
    logic [9:0]  avs_address = 10'h000;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0]  avs_byteenable = 4'hF;
    wire  [31:0] avs_readdata;
    wire         avs_waitrequest;
    wire  [1:0]  avs_response;
    wire  [19:0] quiet_cycles;
    wire  [20:0] shock_cycles;
    wire  [23:0] window_cycles;
    wire  [20:0] knock_threshold_cmg;
    wire  [9:0]  hyst_cmg;
    wire         low_power_en;
    wire         irq;
    int          fail_count = 0;
    int          cmp_count = 0;
    logic [7:0]  rdv;
    logic [1:0]  rsp;
    always #25 clk = ~clk;
    tdc_regs dut (.clk, .nrst, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable, .avs_readdata, .avs_waitrequest, .avs_response, .quiet_cycles,
        .shock_cycles, .window_cycles, .knock_threshold_cmg, .hyst_cmg, .low_power_en, .irq);
    ////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            fail_count++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [9:0] a, input logic [7:0] d,
        input logic [3:0] be);
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= {24'h0, d};
        avs_byteenable <= be;
        avs_read <= !w;
        avs_write <= w;
        // Wait for the edge with waitrequest low; only the watchdog ends a hang
        @(posedge clk);
        while (avs_waitrequest !== 1'b0)
            @(posedge clk);
        rdv = avs_readdata[7:0];
        rsp = avs_response;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        bus(1'b1, a, d, 4'hF);
    endtask
    task automatic rdc(input logic [9:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00, 4'hF);
        chk(rdv, e);
    endtask
    task automatic settle;
        repeat (3) @(negedge clk);
    endtask
    ////////////////////////////////////////
    task automatic t_reset;
        rdc(10'h18C, 8'h04);
        rdc(10'h190, 8'h0A);
        rdc(10'h194, 8'h18);
        settle;
        chk(quiet_cycles, 32'd600000);
        chk(shock_cycles, 32'd1000000);
        chk(window_cycles, 32'd5000000);
        chk(knock_threshold_cmg, 32'd62500);
        chk(hyst_cmg, 32'd62);
        chk({low_power_en, irq}, 32'd0);
    endtask
    task automatic t_timing;
        int ms [8] = '{50, 100, 150, 200, 250, 375, 500, 700};
        logic [7:0] v;
        for (int i = 0; i < 8; i++)
        begin
            v = {i[0], i[1], 3'b000, i[2:0]};
            wr(10'h18C, v);
            rdc(10'h18C, v);
            settle;
            chk(quiet_cycles, v[7] ? 32'd400000 : 32'd600000);
            chk(shock_cycles, v[6] ? 32'd1500000 : 32'd1000000);
            chk(window_cycles, ms[i] * 20000);
        end
        wr(10'h18C, 8'hC7);
        rdc(10'h18C, 8'hC7);
    endtask
    task automatic t_thresh;
        int c [4] = '{0, 1, 5, 31};
        for (int r = 0; r < 4; r++)
            for (int k = 0; k < 4; k++)
            begin
                wr(10'h1C0, 8'(r));
                wr(10'h190, 8'(c[k]));
                rdc(10'h190, 8'(c[k]));
                settle;
                chk(knock_threshold_cmg, (c[k] == 0 ? 3125 : c[k] * 6250) << r);
            end
    endtask
    task automatic t_orient;
        wr(10'h194, 8'h40);
        rdc(10'h194, 8'h40);
        settle;
        chk(hyst_cmg, 32'd250);
    endtask
    task automatic t_refuse;
        bus(1'b0, 10'h3FC, 8'h00, 4'hF);
        chk({rsp, rdv}, 32'h300);
        bus(1'b1, 10'h3FC, 8'hFF, 4'hF);
        bus(1'b1, 10'h18C, 8'h00, 4'h0);
        rdc(10'h18C, 8'hC7);
    endtask
    task automatic t_lowpow;
        wr(10'h1CC, 8'h03);
        wr(10'h160, 8'h00);
        wr(10'h1C0, 8'h04);
        wr(10'h1C8, 8'h03);
        settle;
        chk({low_power_en, irq}, 32'h2);
        wr(10'h160, 8'h08);
        rdc(10'h1C4, 8'h01);
        settle;
        chk({low_power_en, irq}, 32'h1);
        wr(10'h160, 8'h00);
        wr(10'h1C8, 8'h03);
        settle;
        chk({low_power_en, irq}, 32'h2);
        wr(10'h1CC, 8'h00);
        wr(10'h18C, 8'h04);
        settle;
        chk(irq, 32'h0);
        wr(10'h1CC, 8'h01);
        settle;
        chk(irq, 32'h1);
    endtask
    task automatic stop_test;
        $display("Checks %0d, mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    ////////////////////////////////////////
    initial
    begin
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        t_reset;
        t_timing;
        t_thresh;
        t_orient;
        t_refuse;
        t_lowpow;
        stop_test;
    end
    initial
    begin
        #2000000;
        fail_count++;
        stop_test;
    end
endmodule // tdc_regs_tb_top
